/* logic/cpu_core_cfg.svh */
`ifndef CPU_CORE_CFG_SVH
`define CPU_CORE_CFG_SVH

// Extended control field positions
`define XCTL_TRACE_BIT    7
`define XCTL_RSVD_MSB     6
`define XCTL_RSVD_LSB     3
`define XCTL_MASK_MSB     2
`define XCTL_MASK_LSB     0
// Reset values: trace off, reserved ones, mask level 7
`define XCTL_RESET        8'h7F
`define XCTL_RSVD_ONES    8'h78
// Condition flags come up with the interrupt mask bit set
`define CFLAGS_RESET      8'h80
// Interrupts blocked after an extended control update, in states
`define IRQ_BLOCK_STATES  2'h3
// Address widths
`define NARROW_EA_BITS    16
`define WIDE_EA_BITS      24
// This variant: narrow mode absent, extended control present
`define NARROW_AVAILABLE  1'b0
`define XCTL_PRESENT      1'b1
// Vector entry size in bytes per mode (shift amounts)
`define NARROW_VEC_SHIFT  1
`define WIDE_VEC_SHIFT    2
// Stack pointer register index
`define SP_INDEX          3'h7

`endif

/* logic/cpu_core_pkg.sv */
package cpu_core_pkg;

	// Operating mode as strapped by the mode pins
	typedef enum logic {MODE_NARROW, MODE_WIDE} op_mode_t;

	// Control register instruction kinds
	typedef enum logic [2:0]
	{
		OP_LOAD,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_STORE
	} ctl_op_t;

	// Data access size on the general registers
	typedef enum logic [1:0] {SZ_LONG, SZ_WORD, SZ_BYTE} acc_size_t;

	// Register selector: size, upper half for words, high byte for bytes
	typedef struct packed
	{
		logic [2:0] idx;
		acc_size_t  size;
		logic       upper;
	} reg_sel_t;

	// General register write
	typedef struct packed
	{
		logic        en;
		reg_sel_t    sel;
		logic [31:0] data;
	} gpr_wr_t;

	// Pointer pre-decrement or post-increment
	typedef struct packed
	{
		logic       en;
		logic [2:0] idx;
		logic       dec;
		logic [2:0] amount;
	} ptr_step_t;

	// Control register instruction
	typedef struct packed
	{
		logic      valid;
		ctl_op_t   op;
		logic      to_xctl;
		logic [7:0] data;
	} ctl_req_t;

endpackage

/* logic/cpu_reg_model.sv */
// Contract
// - Narrow 64-kbyte and wide 16-Mbyte modes exist
// - Narrow mode unavailable here; wide only
// - Narrow pointer step carries into upper half
// - Narrow mode uses low 16 address bits
// - Narrow vectors start at zero, 16-bit each
// - Narrow indirect: 8-bit pointer, 16-bit target
// - Control mode 0 never stacks extended control
// - Wide vectors 32-bit, low 24 bits used
// - Wide indirect target: longword, top byte zero
// - Wide mode stacks extended control only if valid
// - Program counter 24, control and flags 8
// - Eight 32-bit registers, 32/16/8-bit access
// - Independent halves and bytes of each register
// - Last general register is the stack pointer
// - Fetch address forces program counter bit 0 low
// - Control updates except store block interrupts three states; here only extended control updates do
// - Trace bit set raises trace after each instruction
// - Extended control bits 6..3 read as one
// - Mask level bits 2..0 read/write, reset ones
`timescale 1ns/1ps
`include "cpu_core_cfg.svh"

module cpu_reg_model
(
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_sys_rst,
	// Mode strap pin, high asks for wide mode
	input  wire logic                   i_mode_wide_pin,
	// General register access
	input  wire cpu_core_pkg::gpr_wr_t   i_gpr_wr,
	input  wire cpu_core_pkg::ptr_step_t i_ptr_step,
	input  wire cpu_core_pkg::reg_sel_t  i_rd_sel,
	// Program counter load and instruction completion
	input  wire logic                   i_pc_load,
	input  wire logic [23:0]            i_pc_data,
	input  wire logic                   i_insn_done,
	// Control register instructions
	input  wire cpu_core_pkg::ctl_req_t  i_ctl_req,
	// Address formatting inputs
	input  wire logic [31:0]            i_eff_addr,
	input  wire logic [7:0]             i_vec_num,
	input  wire logic [7:0]             i_ind_ptr,
	input  wire logic [31:0]            i_mem_word,
	input  wire logic                   i_irq_ctrl_mode1,
	// Register views
	output logic [31:0]                 o_rd_data,
	output logic [31:0]                 o_stack_ptr,
	output logic [23:0]                 o_fetch_addr,
	output logic [7:0]                  o_ext_ctrl,
	output logic [7:0]                  o_cond_flags,
	output logic [7:0]                  o_ctl_rd_data,
	// Formatted addresses
	output logic [23:0]                 o_bus_addr,
	output logic [23:0]                 o_vec_addr,
	output logic [23:0]                 o_ind_addr,
	output logic [23:0]                 o_branch_target,
	// Status
	output logic                        o_mode_wide,
	output logic                        o_push_xctl,
	output logic                        o_irq_block,
	output logic                        o_trace_req,
	output logic [2:0]                  o_irq_mask_level
);

	// Merge a write into a register according to the selector
	function automatic logic [31:0] merge_wr(input logic [31:0] old,
		input cpu_core_pkg::reg_sel_t sel, input logic [31:0] val);
		logic [31:0] r;
		r = old;
		case (sel.size)
			cpu_core_pkg::SZ_LONG: r = val;
			cpu_core_pkg::SZ_WORD:
				if (sel.upper)
					r[31:16] = val[15:0];
				else
					r[15:0] = val[15:0];
			cpu_core_pkg::SZ_BYTE:
				if (sel.upper)
					r[15:8] = val[7:0];
				else
					r[7:0] = val[7:0];
			default: r = old;
		endcase
		return r;
	endfunction

	// Extract a view of a register, zero extended
	function automatic logic [31:0] view_rd(input logic [31:0] reg_v,
		input cpu_core_pkg::reg_sel_t sel);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (sel.size)
			cpu_core_pkg::SZ_LONG: r = reg_v;
			cpu_core_pkg::SZ_WORD:
				r[15:0] = sel.upper ? reg_v[31:16] : reg_v[15:0];
			cpu_core_pkg::SZ_BYTE:
				r[7:0] = sel.upper ? reg_v[15:8] : reg_v[7:0];
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Mode pin synchroniser; only stage 2 reads stage 1
	logic        mode_s1_q;
	logic        mode_s2_q;
	logic        mode_s3_q;
	cpu_core_pkg::op_mode_t mode_q;
	cpu_core_pkg::op_mode_t mode_d;

	// Architectural state
	logic [31:0] gpr_q [8];          // General register file
	logic [31:0] gpr_d [8];
	logic [23:0] pc_q;               // Program counter
	logic [7:0]  xctl_q;             // Extended control, writable bits
	logic [7:0]  cflags_q;           // Condition flags
	logic [1:0]  block_cnt_q;        // Interrupt block countdown

	// Mode strap: pins choose, software has no path to this
	always_ff @(posedge i_clock)
	begin
		mode_s1_q <= i_mode_wide_pin;
		mode_s2_q <= mode_s1_q;
		mode_s3_q <= mode_s2_q;
	end
	// Change counts once stages two and three agree
	wire pins_stable = (mode_s2_q == mode_s3_q);
	// Narrow is refused on this variant, whatever the pins say
	wire want_narrow = !mode_s3_q && `NARROW_AVAILABLE;
	assign mode_d = !pins_stable ? mode_q :
		(want_narrow ? cpu_core_pkg::MODE_NARROW
		             : cpu_core_pkg::MODE_WIDE);

	// Wide mode is the safe default out of reset
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			mode_q <= cpu_core_pkg::MODE_WIDE;
		else
			mode_q <= mode_d;
	end
	wire is_narrow = (mode_q == cpu_core_pkg::MODE_NARROW);

	// Per-register next value; a write beats a step on the same index
	// so a load into the pointer is never lost to an old increment
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : gen_gpr
			wire hit_wr   = i_gpr_wr.en && (i_gpr_wr.sel.idx == g);
			wire hit_step = i_ptr_step.en && (i_ptr_step.idx == g);
			// Full 32-bit add, so a carry out of the low half reaches
			// the upper half in either mode
			wire [31:0] step_val = i_ptr_step.dec
				? gpr_q[g] - {29'h0, i_ptr_step.amount}
				: gpr_q[g] + {29'h0, i_ptr_step.amount};
			assign gpr_d[g] = hit_wr
				? merge_wr(gpr_q[g], i_gpr_wr.sel, i_gpr_wr.data)
				: (hit_step ? step_val : gpr_q[g]);
		end
	endgenerate

	// Register file update
	always_ff @(posedge i_clock)
	begin
		for (int i = 0; i < 8; i++)
			gpr_q[i] <= i_sys_rst ? 32'h0000_0000 : gpr_d[i];
	end

	// Program counter, 24 bits wide
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			pc_q <= 24'h00_0000;
		else if (i_pc_load)
			pc_q <= i_pc_data;
	end

	// Control instruction decode
	wire ctl_alter = i_ctl_req.valid &&
		(i_ctl_req.op != cpu_core_pkg::OP_STORE);
	wire xctl_alter = ctl_alter && i_ctl_req.to_xctl && `XCTL_PRESENT;
	wire flags_alter = ctl_alter && !i_ctl_req.to_xctl;

	// Apply an instruction to a control register value
	function automatic logic [7:0] ctl_apply(input logic [7:0] old,
		input cpu_core_pkg::ctl_op_t op, input logic [7:0] val);
		case (op)
			cpu_core_pkg::OP_LOAD: return val;
			cpu_core_pkg::OP_AND:  return old & val;
			cpu_core_pkg::OP_OR:   return old | val;
			cpu_core_pkg::OP_XOR:  return old ^ val;
			default:               return old;
		endcase
	endfunction

	// Reserved bits are forced on in the stored image
	wire [7:0] xctl_view = xctl_q | `XCTL_RSVD_ONES;
	wire [7:0] xctl_new  = ctl_apply(xctl_view, i_ctl_req.op,
		i_ctl_req.data) | `XCTL_RSVD_ONES;
	// Extended control: trace and mask level writable
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			xctl_q <= `XCTL_RESET;
		else if (xctl_alter)
			xctl_q <= xctl_new;
	end

	// Condition flags
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			cflags_q <= `CFLAGS_RESET;
		else if (flags_alter)
			cflags_q <= ctl_apply(cflags_q, i_ctl_req.op, i_ctl_req.data);
	end

	// Interrupt block: restarts on every extended control altering op, store excluded
	wire [1:0] block_cnt_d = xctl_alter ? `IRQ_BLOCK_STATES
		: (block_cnt_q != 2'h0 ? block_cnt_q - 2'h1 : 2'h0);
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			block_cnt_q <= 2'h0;
		else
			block_cnt_q <= block_cnt_d;
	end
	// Address formatting: narrow keeps low 16 bits
	wire [23:0] bus_addr_d = is_narrow
		? {8'h00, i_eff_addr[15:0]} : i_eff_addr[23:0];
	// Vectors from address zero, 2 or 4 bytes apart
	wire [23:0] vec_addr_d = is_narrow
		? {16'h0000, i_vec_num} << `NARROW_VEC_SHIFT
		: {16'h0000, i_vec_num} << `WIDE_VEC_SHIFT;
	// Indirect pointer lies in the first 256 bytes
	wire [23:0] ind_addr_d = {16'h0000, i_ind_ptr};
	// Branch target: word in narrow, low 24 bits of longword in wide
	wire [23:0] target_d = is_narrow
		? {8'h00, i_mem_word[15:0]}
		: i_mem_word[23:0];

	// Extended control stacked only in wide mode, when present, and
	// never in interrupt control mode 0
	wire push_xctl_d = !is_narrow && `XCTL_PRESENT
		&& i_irq_ctrl_mode1;
	// Control register read path; store reads the selected register
	wire [7:0] ctl_rd_d = i_ctl_req.to_xctl ? xctl_view : cflags_q;
	// Output registers, every output straight from a flip-flop
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			o_rd_data        <= 32'h0000_0000;
			o_stack_ptr      <= 32'h0000_0000;
			o_fetch_addr     <= 24'h00_0000;
			o_ext_ctrl       <= `XCTL_RESET;
			o_cond_flags     <= `CFLAGS_RESET;
			o_ctl_rd_data    <= 8'h00;
			o_bus_addr       <= 24'h00_0000;
			o_vec_addr       <= 24'h00_0000;
			o_ind_addr       <= 24'h00_0000;
			o_branch_target  <= 24'h00_0000;
			o_mode_wide      <= 1'b1;
			o_push_xctl      <= 1'b0;
			o_irq_block      <= 1'b0;
			o_trace_req      <= 1'b0;
			o_irq_mask_level <= 3'h7;
		end
		else
		begin
			o_rd_data        <= view_rd(gpr_q[i_rd_sel.idx], i_rd_sel);
			o_stack_ptr      <= gpr_q[`SP_INDEX];
			o_fetch_addr     <= {pc_q[23:1], 1'b0};
			o_ext_ctrl       <= xctl_view;
			o_cond_flags     <= cflags_q;
			o_ctl_rd_data    <= ctl_rd_d;
			o_bus_addr       <= bus_addr_d;
			o_vec_addr       <= vec_addr_d;
			o_ind_addr       <= ind_addr_d;
			o_branch_target  <= target_d;
			o_mode_wide      <= !is_narrow;
			o_push_xctl      <= push_xctl_d;
			o_irq_block      <= block_cnt_d != 2'h0;
			o_trace_req      <= i_insn_done
				&& xctl_view[`XCTL_TRACE_BIT];
			o_irq_mask_level <= xctl_view[`XCTL_MASK_MSB:`XCTL_MASK_LSB];
		end
	end
	// Checks; the block output rises at the same edge that takes the request
	a_rsvd_ones: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) o_ext_ctrl[6:3] == 4'hF)
		else $error("reserved control bits not one");
	a_wide_only: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) o_mode_wide && !is_narrow)
		else $error("narrow mode entered");
	a_fetch_even: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) !$past(i_sys_rst)
		|-> o_fetch_addr == {$past(pc_q[23:1]), 1'b0})
		else $error("fetch address not even pc");
	a_block_three: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) xctl_alter |=> o_irq_block [*3] ##1
		(!o_irq_block || $past(xctl_alter) || $past(xctl_alter, 2)
		|| $past(xctl_alter, 3)))
		else $error("interrupt block not three states");
	a_store_noblk: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(block_cnt_q == 2'h0 && !xctl_alter) |=> !o_irq_block)
		else $error("block raised without control update");
	a_trace_follow: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_insn_done && xctl_view[7]) |=> o_trace_req)
		else $error("trace request missing");
	a_trace_quiet: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) !xctl_view[7] |=> !o_trace_req)
		else $error("trace request while trace off");
	a_push_gate: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) !i_irq_ctrl_mode1 |=> !o_push_xctl)
		else $error("control stacked in mode 0");
	a_mask_load: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(xctl_alter && i_ctl_req.op == cpu_core_pkg::OP_LOAD)
		|=> ##1 o_irq_mask_level == $past(i_ctl_req.data[2:0], 2))
		else $error("mask level not loaded");
	a_step_carry: assert property (@(posedge i_clock)
		disable iff (i_sys_rst) (i_ptr_step.en && !i_gpr_wr.en)
		|=> gpr_q[$past(i_ptr_step.idx)] == $past(i_ptr_step.dec
		? gpr_q[i_ptr_step.idx] - {29'h0, i_ptr_step.amount}
		: gpr_q[i_ptr_step.idx] + {29'h0, i_ptr_step.amount}))
		else $error("pointer step lost carry");
	a_wide_target: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		!is_narrow |=> o_branch_target == $past(i_mem_word[23:0]))
		else $error("wide target top byte not dropped");

endmodule

/* tb/cpu_mem_partner.sv */
`timescale 1ns/1ps
// Far-side memory model: answers every address with a longword derived from it
module cpu_mem_partner
(
	// Clock
	input  wire logic        i_clock,
	// Byte address from the core
	input  wire logic [23:0] i_addr,
	// Read data; top byte is non-zero so the core must drop it
	output logic      [31:0] o_data
);
	// One cycle read latency, as a synchronous memory would give
	always_ff @(posedge i_clock)
	begin
		o_data <= {8'hC3, i_addr ^ 24'h5A5A5A};
	end
endmodule

/* tb/cpu_reg_model_tb_top.sv */
`timescale 1ns/1ps
module cpu_reg_model_tb_top;
	logic                      clock;    // 100 MHz
	logic                      sys_rst;  // Synchronous reset
	logic                      mode_pin; // Mode strap
	cpu_core_pkg::gpr_wr_t     wr;       // Register write
	cpu_core_pkg::ptr_step_t   st;       // Pointer step
	cpu_core_pkg::reg_sel_t    rsel;     // Read selector
	logic                      pc_ld;    // Program counter load
	logic [23:0]               pc_d;     // Program counter value
	logic                      done;     // Instruction completed
	cpu_core_pkg::ctl_req_t    req;      // Control instruction
	logic [31:0]               ea;       // Effective address
	logic [7:0]                vec;      // Vector number
	logic [7:0]                iptr;     // Indirect pointer
	logic [31:0]               mword;    // Memory word from partner
	logic                      icm1;     // Interrupt control mode 1
	logic [31:0]               rd, sp;   // Register views
	logic [23:0]               fa, ba, va, ia, bt;
	logic [7:0]                xc, cf, cr;
	logic                      mw, px, blk, trc;
	logic [2:0]                ml;
	int                        n_errors; // Mismatches
	int                        checks;   // Comparisons made

	cpu_reg_model i_dut (.i_clock(clock), .i_sys_rst(sys_rst),
		.i_mode_wide_pin(mode_pin), .i_gpr_wr(wr), .i_ptr_step(st),
		.i_rd_sel(rsel), .i_pc_load(pc_ld), .i_pc_data(pc_d),
		.i_insn_done(done), .i_ctl_req(req), .i_eff_addr(ea),
		.i_vec_num(vec), .i_ind_ptr(iptr), .i_mem_word(mword),
		.i_irq_ctrl_mode1(icm1), .o_rd_data(rd), .o_stack_ptr(sp),
		.o_fetch_addr(fa), .o_ext_ctrl(xc), .o_cond_flags(cf),
		.o_ctl_rd_data(cr), .o_bus_addr(ba), .o_vec_addr(va),
		.o_ind_addr(ia), .o_branch_target(bt), .o_mode_wide(mw),
		.o_push_xctl(px), .o_irq_block(blk), .o_trace_req(trc),
		.o_irq_mask_level(ml));

	// Memory answers indirect fetches at the formatted address
	cpu_mem_partner i_mem (.i_clock(clock), .i_addr(ia), .o_data(mword));

	// Clock generator
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Verdict and end of run
	task automatic close_out();
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Compare and report at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Write a register view, held for one edge
	task automatic wgpr(input logic [2:0] idx,
		input cpu_core_pkg::acc_size_t sz, input logic up,
		input logic [31:0] d);
		@(posedge clock) wr <= '{1'b1, '{idx, sz, up}, d};
		@(posedge clock) wr.en <= 1'b0;
	endtask

	// Read a register view; data shows one edge after the selector
	task automatic rgpr(input logic [2:0] idx,
		input cpu_core_pkg::acc_size_t sz, input logic up,
		input logic [31:0] exp);
		@(posedge clock) rsel <= '{idx, sz, up};
		@(posedge clock);
		#1 chk(rd, exp);
	endtask

	// Control instruction; counts the cycles interrupts stay blocked
	task automatic ctl(input cpu_core_pkg::ctl_op_t op, input logic to,
		input logic [7:0] d, input int nblk);
		int n;
		n = 0;
		@(posedge clock) req <= '{1'b1, op, to, d};
		@(posedge clock) req.valid <= 1'b0;
		// Block rises at the edge that takes the request, so the
		// count starts just after that edge
		repeat (6)
		begin
			#1 if (blk === 1'b1) n++;
			@(posedge clock);
		end
		#1 chk(n, nblk);
	endtask

	// Hang guard: a run that stalls counts as a mismatch
	initial
	begin
		#200000;
		n_errors++;
		close_out();
	end

	// Main sequence
	initial
	begin
		n_errors = 0;
		checks = 0;
		sys_rst = 1'b1;
		mode_pin = 1'b0; // Ask for narrow mode; the variant refuses it
		wr = '0;
		st = '0;
		rsel = '0;
		pc_ld = 1'b0;
		pc_d = '0;
		done = 1'b0;
		req = '0;
		ea = 32'h12345678;
		vec = 8'h10;
		iptr = 8'hFF;
		icm1 = 1'b0;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		#1 chk(xc, 32'h7F);
		chk(ml, 32'h7);
		chk(cf, 32'h80);
		repeat (4) @(posedge clock);
		// Wide mode whatever the strap says; full 24-bit addresses
		#1 chk(mw, 32'h1);
		chk(ba, 32'h345678);
		chk(va, 32'h40);
		chk(ia, 32'hFF);
		chk(bt, 32'h5A5AA5);
		chk(px, 32'h0);
		// Halves and bytes are written independently
		wgpr(3'h3, cpu_core_pkg::SZ_LONG, 1'b0, 32'h11223344);
		wgpr(3'h3, cpu_core_pkg::SZ_WORD, 1'b1, 32'h0000AAAA);
		wgpr(3'h3, cpu_core_pkg::SZ_BYTE, 1'b1, 32'h00000055);
		rgpr(3'h3, cpu_core_pkg::SZ_LONG, 1'b0, 32'hAAAA5544);
		rgpr(3'h3, cpu_core_pkg::SZ_WORD, 1'b0, 32'h5544);
		rgpr(3'h3, cpu_core_pkg::SZ_BYTE, 1'b0, 32'h44);
		// Stack pointer decrement borrows into the upper half
		wgpr(3'h7, cpu_core_pkg::SZ_LONG, 1'b0, 32'h00010002);
		@(posedge clock) st <= '{1'b1, 3'h7, 1'b1, 3'h4};
		@(posedge clock) st.en <= 1'b0;
		@(posedge clock);
		#1 chk(sp, 32'h0000FFFE);
		rgpr(3'h7, cpu_core_pkg::SZ_LONG, 1'b0, 32'h0000FFFE);
		// Increment carries back into the upper half
		@(posedge clock) st <= '{1'b1, 3'h7, 1'b0, 3'h4};
		@(posedge clock) st.en <= 1'b0;
		@(posedge clock);
		#1 chk(sp, 32'h00010002);
		// Odd program counter fetches from the even address
		@(posedge clock) pc_ld <= 1'b1;
		pc_d <= 24'h123457;
		@(posedge clock) pc_ld <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk(fa, 32'h123456);
		// Trace bit set, reserved bits stay ones
		ctl(cpu_core_pkg::OP_LOAD, 1'b1, 8'h80, 3);
		chk(xc, 32'hF8);
		// Trace pulse follows the edge that samples the completion
		@(posedge clock) done <= 1'b1;
		@(posedge clock) done <= 1'b0;
		#1 chk(trc, 32'h1);
		@(posedge clock);
		#1 chk(trc, 32'h0);
		// Store only reads; flag updates never block
		ctl(cpu_core_pkg::OP_STORE, 1'b1, 8'h00, 0);
		chk(cr, 32'hF8);
		ctl(cpu_core_pkg::OP_AND, 1'b1, 8'h00, 3);
		chk(xc, 32'h78);
		ctl(cpu_core_pkg::OP_OR, 1'b1, 8'h07, 3);
		chk(ml, 32'h7);
		ctl(cpu_core_pkg::OP_XOR, 1'b1, 8'h05, 3);
		chk(xc, 32'h7A);
		@(posedge clock) done <= 1'b1;
		@(posedge clock) done <= 1'b0;
		#1 chk(trc, 32'h0);
		ctl(cpu_core_pkg::OP_LOAD, 1'b0, 8'h3C, 0);
		chk(cf, 32'h3C);
		// Control mode 1 stacks extended control in wide mode
		@(posedge clock) icm1 <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk(px, 32'h1);
		// Strapping the pin wide later changes nothing on this variant
		@(posedge clock) mode_pin <= 1'b1;
		repeat (6) @(posedge clock);
		#1 chk(mw, 32'h1);
		close_out();
	end
endmodule
